// [src/addr_map_pkg.sv]
// Address map constants for the system address decoder and router.
// Assumes a single bus clock; all addresses are byte addresses.
package addr_map_pkg;

  // Top level regions of the 4 GB space.
  localparam logic [31:0] CODE_BASE       = 32'h0000_0000;
  localparam logic [31:0] CODE_LAST       = 32'h1FFF_FFFF;
  localparam logic [31:0] SRAM_BASE       = 32'h2000_0000;
  localparam logic [31:0] SRAM_LAST       = 32'h3FFF_FFFF;
  localparam logic [31:0] PERIPH_BASE     = 32'h4000_0000;
  localparam logic [31:0] EXT_RAM_BASE    = 32'h6000_0000;
  localparam logic [31:0] EXT_PERIPH_BASE = 32'hA000_0000;
  localparam logic [31:0] INT_PERIPH_BASE = 32'hE000_0000;

  // Bit-band: 1 MByte of SRAM mirrored bit by bit into a 32 Mbyte alias.
  localparam logic [31:0] BB_REGION_BASE  = 32'h2000_0000;
  localparam logic [31:0] BB_ALIAS_BASE   = 32'h2200_0000;
  localparam logic [31:0] BB_ALIAS_LAST   = 32'h23FF_FFFF;

  // Memory windows.
  localparam logic [31:0] FLASH_BASE      = 32'h0000_0000;
  localparam logic [31:0] FLASH_LAST      = 32'h0003_FFFF;
  localparam logic [31:0] SRAM_CODE_BASE  = 32'h1FFF_8000;
  localparam logic [31:0] SRAM_CODE_LAST  = 32'h1FFF_FFFF;
  localparam logic [31:0] SRAM_SYS_BASE   = 32'h2000_0000;
  localparam logic [31:0] SRAM_SYS_LAST   = 32'h2000_7FFF;
  localparam logic [31:0] EXT_WIN_BASE    = 32'h6000_0000;
  localparam logic [31:0] EXT_WIN_LAST    = 32'h60FF_FFFF;
  localparam logic [31:0] PPB_BASE        = 32'hE000_0000;
  localparam logic [31:0] PPB_LAST        = 32'hE00F_FFFF;

  // Region one-hot positions.
  localparam int REGION_CODE = 0;
  localparam int REGION_SRAM = 1;
  localparam int REGION_PERIPH = 2;
  localparam int REGION_EXT_RAM = 3;
  localparam int REGION_EXT_PERIPH = 4;
  localparam int REGION_INT_PERIPH = 5;
  localparam int NUM_REGIONS = 6;

  // Target bus indices; the first four leave the block as plain ports.
  localparam logic [2:0] BUS_INSTRUCTION_CODE_BUS = 3'h0;
  localparam logic [2:0] BUS_DATA_CODE_BUS = 3'h1;
  localparam logic [2:0] BUS_SYS   = 3'h2;
  localparam logic [2:0] BUS_PPB   = 3'h3;
  localparam logic [2:0] BUS_EXT   = 3'h4;
  localparam int NUM_OUT_BUSES = 4;

  // Peripheral windows, inclusive bounds.
  localparam int NUM_PWIN = 19;
  localparam int PWIN_EXT_CTRL = 9;
  localparam logic [31:0] PWIN_LO [NUM_PWIN] = '{
    32'h4000_4000, 32'h4000_4300, 32'h4000_4500, 32'h4000_4700, 32'h4000_4800,
    32'h4000_4900, 32'h4000_4E00, 32'h4000_4F00, 32'h4000_5000, 32'h4000_5400,
    32'h4000_5800, 32'h4000_6000, 32'h4000_6400, 32'h4000_7000, 32'h4000_8000,
    32'h4000_A000, 32'h4000_C000, 32'h4001_0000, 32'h4800_0000};
  localparam logic [31:0] PWIN_HI [NUM_PWIN] = '{
    32'h4000_42FF, 32'h4000_43FF, 32'h4000_45FF, 32'h4000_47FF, 32'h4000_48FF,
    32'h4000_49FF, 32'h4000_4EFF, 32'h4000_4FFF, 32'h4000_51FF, 32'h4000_54FF,
    32'h4000_5FFF, 32'h4000_60FF, 32'h4000_6FFF, 32'h4000_7FFF, 32'h4000_87FF,
    32'h4000_A400, 32'h4000_C800, 32'h4001_FFFF, 32'h4800_7FFF};

  // External memory port.
  localparam int EXT_ADDR_W = 24;
  localparam int EXT_DATA_W = 16;
  localparam int EXT_CYCLE_CLKS = 4;
  localparam logic [1:0] EXT_LAST_PHASE = 2'(EXT_CYCLE_CLKS - 1);

  // Reset values.
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage

// [src/ext_req_if.sv]
// Request channel between the router and the external memory port.
// Assumes both ends run on the same bus clock.
interface ext_req_if;
  logic        valid;
  logic        ready;
  logic [23:0] addr;
  logic        write;
  logic [3:0]  strb;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wide16;

  modport router (output valid, addr, write, strb, wdata, input ready, rdata, wide16);
  modport port   (input valid, addr, write, strb, wdata, output ready, rdata, wide16);
endinterface

// [src/ext_mem_port.sv]
// External memory port engine: turns one word request into 8 or 16 bit
// external cycles of fixed length. Assumes request fields hold until ready.
module ext_mem_port (
  input  wire logic                              core_clk,
  input  wire logic                              rst_n,
  ext_req_if.port                                req,
  input  wire logic                              extWide16,
  input  wire logic                              extSyncMem,
  output logic [addr_map_pkg::EXT_ADDR_W-1:0]    extAddr,
  input  wire logic [addr_map_pkg::EXT_DATA_W-1:0] extDataIn,
  output logic [addr_map_pkg::EXT_DATA_W-1:0]    extDataOut,
  output logic                                   extDataOe,
  output logic                                   extCsN,
  output logic                                   extOeN,
  output logic                                   extWeN,
  output logic                                   extAdvN,
  output logic                                   extMemClk
);
  import addr_map_pkg::*;

  logic [15:0] dinMeta_q;
  logic [15:0] dinSync_q;
  logic        wide_q;
  logic        sync_q;
  logic        busy_q;
  logic        done_q;
  logic [1:0]  unit_q;
  logic [1:0]  phase_q;
  logic [31:0] rdata_q;
  wire  [1:0]  unitStrb  = wide_q ? req.strb[{unit_q[0], 1'b0} +: 2] : {1'b0, req.strb[unit_q]};
  wire         unitOn    = |unitStrb;
  wire         lastUnit  = wide_q ? (unit_q == 2'd1) : (unit_q == 2'd3);
  wire         cycleOn   = busy_q && unitOn;
  wire         unitEnd   = busy_q && (!unitOn || phase_q == EXT_LAST_PHASE);
  wire [1:0]   byteOff   = wide_q ? {unit_q[0], 1'b0} : unit_q;
  wire [15:0]  wrData    = wide_q ? req.wdata[{unit_q[0], 4'h0} +: 16]
                                  : {8'h00, req.wdata[{unit_q, 3'h0} +: 8]};
  wire         capture   = cycleOn && !req.write && phase_q == EXT_LAST_PHASE;

  assign extAddr    = {req.addr[23:2], byteOff};
  assign extDataOut = wrData;
  assign extDataOe  = cycleOn && req.write;
  assign extCsN     = !cycleOn;
  assign extOeN     = !(cycleOn && !req.write);
  assign extWeN     = !(cycleOn && req.write && (phase_q == 2'd1 || phase_q == 2'd2));
  assign extAdvN    = !(cycleOn && sync_q && phase_q == 2'd0);
  assign extMemClk  = cycleOn && sync_q && phase_q[0];
  assign req.ready  = done_q;
  assign req.rdata  = rdata_q;
  assign req.wide16 = wide_q;

  // Pin data passes two flops; the sample at the last phase therefore
  // reflects the pin two cycles earlier, inside the strobe.
  always_ff @(posedge core_clk) begin
    dinMeta_q <= extDataIn;
    dinSync_q <= dinMeta_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wide_q <= 1'b0;
      sync_q <= 1'b0;
    // One memory type, frozen while busy.
    end else if (!busy_q && !req.valid) begin
      wide_q <= extWide16;
      sync_q <= extSyncMem;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      unit_q  <= 2'd0;
      phase_q <= 2'd0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && req.valid && !done_q) begin
        busy_q  <= 1'b1;
        unit_q  <= 2'd0;
        phase_q <= 2'd0;
      end else if (unitEnd) begin
        phase_q <= 2'd0;
        unit_q  <= unit_q + 2'd1;
        if (lastUnit) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end else if (busy_q) begin
        phase_q <= phase_q + 2'd1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= RDATA_RST;
    end else if (!busy_q && req.valid && !done_q) begin
      rdata_q <= RDATA_RST;
    end else if (capture && wide_q) begin
      rdata_q[{unit_q[0], 4'h0} +: 16] <= dinSync_q;
    end else if (capture) begin
      rdata_q[{unit_q, 3'h0} +: 8] <= dinSync_q[7:0];
    end
  end
endmodule

// [src/address_decode_router.sv]
// System address decoder and router for the processor's three masters.
// Assumes one bus clock, targets that answer with a one-cycle ready, and
// that the requester holds its request fields while reqValid is high.
//
// Behaviour
// - Split space into peripheral and external regions.
// - Lowest half gigabyte decodes as code.
// - SRAM region holds bit-band base and alias.
// - Top half gigabyte is internal peripherals.
// - Code-side SRAM block selected below SRAM.
// - System-side SRAM block selected at base.
// - Separate select for each peripheral window.
// - External port control window has own select.
// - External window accesses go to port.
// - Alias word bit 0 acts on one bit.
// - Unaligned word and half accesses accepted.
// - Code buses carry only code range.
// - Other data and debug use system bus.
// - Fetches allowed on system bus in SRAM.
// - Private window uses private peripheral bus.
// - External cycle takes four bus clocks.
// - Only one external memory type active.
// - External port drives 24 address bits.
// - External data width is 8 or 16.
// - External fetches only with 16-bit memory.
module address_decode_router (
  input  wire logic                                  core_clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  reqValid,
  input  wire logic [31:0]                           reqAddr,
  input  wire logic                                  reqWrite,
  input  wire logic [1:0]                            reqSize,
  input  wire logic [31:0]                           reqWdata,
  input  wire logic                                  reqFetch,
  input  wire logic                                  reqDebug,
  output logic                                       reqReady,
  output logic                                       rspValid,
  output logic [31:0]                                rspRdata,
  output logic                                       rspError,
  output logic [addr_map_pkg::NUM_REGIONS-1:0]       regionSel,
  output logic [addr_map_pkg::NUM_PWIN-1:0]          periphSel,
  output logic                                       flashSel,
  output logic                                       sramCodeSel,
  output logic                                       sramSysSel,
  output logic [addr_map_pkg::NUM_OUT_BUSES-1:0]     busValid,
  input  wire logic [addr_map_pkg::NUM_OUT_BUSES-1:0] busReady,
  input  wire logic [addr_map_pkg::NUM_OUT_BUSES-1:0][31:0] busRdata,
  output logic [31:0]                                busAddr,
  output logic                                       busWrite,
  output logic [3:0]                                 busStrb,
  output logic [31:0]                                busWdata,
  output logic                                       busLock,
  output logic                                       busDebug,
  input  wire logic                                  extWide16,
  input  wire logic                                  extSyncMem,
  output logic [addr_map_pkg::EXT_ADDR_W-1:0]        extAddr,
  input  wire logic [addr_map_pkg::EXT_DATA_W-1:0]   extDataIn,
  output logic [addr_map_pkg::EXT_DATA_W-1:0]        extDataOut,
  output logic                                       extDataOe,
  output logic                                       extCsN,
  output logic                                       extOeN,
  output logic                                       extWeN,
  output logic                                       extAdvN,
  output logic                                       extMemClk
);
  import addr_map_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LO   = 5'b00010,
    ST_HI   = 5'b00100,
    ST_BBW  = 5'b01000,
    ST_RESP = 5'b10000
  } state_e;

  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [NUM_REGIONS-1:0] regionOf(input logic [31:0] a);
    logic [NUM_REGIONS-1:0] r;
    r = '0;
    case (a[31:29])
      3'h0:       r[REGION_CODE] = 1'b1;
      3'h1:       r[REGION_SRAM] = 1'b1;
      3'h2:       r[REGION_PERIPH] = 1'b1;
      3'h3, 3'h4: r[REGION_EXT_RAM] = 1'b1;
      3'h5, 3'h6: r[REGION_EXT_PERIPH] = 1'b1;
      default:    r[REGION_INT_PERIPH] = 1'b1;
    endcase
    return r;
  endfunction

  // Picks the addressed lanes out of a two-word read and clears the rest.
  function automatic logic [31:0] alignRead(input logic [63:0] w, input logic [1:0] off,
                                            input logic [3:0] mask);
    logic [63:0] s;
    logic [31:0] m;
    s = w >> {off, 3'h0};
    m = {{8{mask[3]}}, {8{mask[2]}}, {8{mask[1]}}, {8{mask[0]}}};
    return s[31:0] & m;
  endfunction

  ext_req_if extIf ();

  state_e      state_q;
  state_e      state_d;
  logic [31:0] busAddr_q;
  logic [31:0] busAddr_d;
  logic [3:0]  busStrb_q;
  logic [3:0]  busStrb_d;
  logic [31:0] busWdata_q;
  logic [31:0] busWdata_d;
  logic        busWrite_q;
  logic        busWrite_d;
  logic [31:0] rdLo_q;
  logic [31:0] rdLo_d;
  logic [31:0] rspRdata_q;
  logic [31:0] rspRdata_d;
  logic        rspErr_q;
  logic        rspErr_d;

  // Request attributes captured at acceptance.
  logic [2:0]  busIdx_q;
  logic [1:0]  off_q;
  logic [3:0]  sizeMask_q;
  logic        bb_q;
  logic [4:0]  bitNum_q;
  logic        wbit_q;
  logic        write_q;
  logic        cross_q;
  logic        debug_q;
  logic [3:0]  hiStrb_q;
  logic [31:0] hiData_q;
  logic [NUM_REGIONS-1:0] region_q;
  logic [NUM_PWIN-1:0]    pwin_q;
  logic        flash_q;
  logic        sramCode_q;
  logic        sramSys_q;

  wire         accept = reqValid && state_q == ST_IDLE;

  wire [NUM_REGIONS-1:0] regionHit = regionOf(reqAddr);
  wire         codeHit   = inRange(reqAddr, CODE_BASE, CODE_LAST);
  wire         aliasHit  = inRange(reqAddr, BB_ALIAS_BASE, BB_ALIAS_LAST);
  wire         ppbHit    = inRange(reqAddr, PPB_BASE, PPB_LAST);
  wire         extHit    = inRange(reqAddr, EXT_WIN_BASE, EXT_WIN_LAST);
  wire         sysFetch  = inRange(reqAddr, SRAM_BASE, SRAM_LAST);
  wire         fetchOk   = codeHit || sysFetch || (extHit && extIf.wide16);
  wire         fetchBad  = reqFetch && !fetchOk;

  // Code buses only for code range.
  wire [2:0]   busSel    = codeHit ? (reqFetch ? BUS_INSTRUCTION_CODE_BUS : BUS_DATA_CODE_BUS)
                         : ppbHit  ? BUS_PPB
                         : extHit  ? BUS_EXT : BUS_SYS;

  wire [31:0]  bbTarget  = BB_REGION_BASE | {12'h000, reqAddr[24:7], 2'b00};
  wire [4:0]   bbBit     = reqAddr[6:2];

  wire [3:0]   sizeMask  = (reqSize == 2'd0) ? 4'b0001
                         : (reqSize == 2'd1) ? 4'b0011 : 4'b1111;
  wire [7:0]   strb64    = {4'h0, sizeMask} << reqAddr[1:0];
  wire [63:0]  data64    = {32'h0000_0000, reqWdata} << {reqAddr[1:0], 3'h0};
  wire         crosses   = |strb64[7:4];

  wire [NUM_PWIN-1:0] pwinHit;
  for (genvar w = 0; w < NUM_PWIN; w++) begin : g_pwin
    assign pwinHit[w] = inRange(reqAddr, PWIN_LO[w], PWIN_HI[w]);
  end

  logic [31:0] allRdata [NUM_OUT_BUSES+1];
  logic [NUM_OUT_BUSES:0] allReady;
  wire         busActive = state_q == ST_LO || state_q == ST_HI || state_q == ST_BBW;

  for (genvar b = 0; b < NUM_OUT_BUSES; b++) begin : g_bus
    assign allRdata[b] = busRdata[b];
    assign busValid[b] = busActive && busIdx_q == 3'(b);
  end
  assign allRdata[NUM_OUT_BUSES] = extIf.rdata;
  assign allReady = {extIf.ready, busReady};

  wire [31:0]  rdNow   = allRdata[busIdx_q];
  wire         rdyNow  = allReady[busIdx_q];
  wire [31:0]  bitMask = 32'h0000_0001 << bitNum_q;
  wire [31:0]  modWord = (rdNow & ~bitMask) | (wbit_q ? bitMask : 32'h0000_0000);

  assign extIf.valid = busActive && busIdx_q == BUS_EXT;
  assign extIf.addr  = busAddr_q[23:0];
  assign extIf.write = busWrite_q;
  assign extIf.strb  = busStrb_q;
  assign extIf.wdata = busWdata_q;

  ext_mem_port u_ext_mem_port (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .req        (extIf),
    .extWide16  (extWide16),
    .extSyncMem (extSyncMem),
    .extAddr    (extAddr),
    .extDataIn  (extDataIn),
    .extDataOut (extDataOut),
    .extDataOe  (extDataOe),
    .extCsN     (extCsN),
    .extOeN     (extOeN),
    .extWeN     (extWeN),
    .extAdvN    (extAdvN),
    .extMemClk  (extMemClk)
  );

  always_comb begin
    state_d    = state_q;
    busAddr_d  = busAddr_q;
    busStrb_d  = busStrb_q;
    busWdata_d = busWdata_q;
    busWrite_d = busWrite_q;
    rdLo_d     = rdLo_q;
    rspRdata_d = rspRdata_q;
    rspErr_d   = rspErr_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          rspErr_d   = 1'b0;
          rspRdata_d = RDATA_RST;
          rdLo_d     = RDATA_RST;
          if (fetchBad) begin
            rspErr_d = 1'b1;
            state_d  = ST_RESP;
          end else if (aliasHit) begin
            busAddr_d  = bbTarget;
            busStrb_d  = 4'hF;
            busWdata_d = RDATA_RST;
            busWrite_d = 1'b0;
            state_d    = ST_LO;
          end else begin
            busAddr_d  = {reqAddr[31:2], 2'b00};
            busStrb_d  = strb64[3:0];
            busWdata_d = data64[31:0];
            busWrite_d = reqWrite;
            state_d    = ST_LO;
          end
        end
      end
      ST_LO: begin
        if (rdyNow) begin
          rdLo_d = rdNow;
          if (bb_q && write_q) begin
            busStrb_d  = 4'b0001 << bitNum_q[4:3];
            busWdata_d = modWord;
            busWrite_d = 1'b1;
            state_d    = ST_BBW;
          end else if (bb_q) begin
            rspRdata_d = {31'h0, rdNow[bitNum_q]};
            state_d    = ST_RESP;
          // Second word of a split access.
          end else if (cross_q) begin
            busAddr_d  = busAddr_q + 32'h0000_0004;
            busStrb_d  = hiStrb_q;
            busWdata_d = hiData_q;
            state_d    = ST_HI;
          end else begin
            rspRdata_d = write_q ? RDATA_RST
                                 : alignRead({32'h0000_0000, rdNow}, off_q, sizeMask_q);
            state_d    = ST_RESP;
          end
        end
      end
      ST_HI: begin
        if (rdyNow) begin
          rspRdata_d = write_q ? RDATA_RST
                               : alignRead({rdNow, rdLo_q}, off_q, sizeMask_q);
          state_d    = ST_RESP;
        end
      end
      ST_BBW: begin
        if (rdyNow) begin
          state_d = ST_RESP;
        end
      end
      ST_RESP: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      busAddr_q  <= RDATA_RST;
      busStrb_q  <= 4'h0;
      busWdata_q <= RDATA_RST;
      busWrite_q <= 1'b0;
      rdLo_q     <= RDATA_RST;
      rspRdata_q <= RDATA_RST;
      rspErr_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      busAddr_q  <= busAddr_d;
      busStrb_q  <= busStrb_d;
      busWdata_q <= busWdata_d;
      busWrite_q <= busWrite_d;
      rdLo_q     <= rdLo_d;
      rspRdata_q <= rspRdata_d;
      rspErr_q   <= rspErr_d;
    end
  end

  // Attributes and selects hold the last accepted request until the next.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busIdx_q   <= BUS_SYS;
      off_q      <= 2'd0;
      sizeMask_q <= 4'h0;
      bb_q       <= 1'b0;
      bitNum_q   <= 5'd0;
      wbit_q     <= 1'b0;
      write_q    <= 1'b0;
      cross_q    <= 1'b0;
      debug_q    <= 1'b0;
      hiStrb_q   <= 4'h0;
      hiData_q   <= RDATA_RST;
      region_q   <= '0;
      pwin_q     <= '0;
      flash_q    <= 1'b0;
      sramCode_q <= 1'b0;
      sramSys_q  <= 1'b0;
    end else if (accept) begin
      busIdx_q   <= aliasHit ? BUS_SYS : busSel;
      off_q      <= reqAddr[1:0];
      sizeMask_q <= sizeMask;
      bb_q       <= aliasHit;
      bitNum_q   <= bbBit;
      wbit_q     <= reqWdata[0];
      write_q    <= reqWrite;
      cross_q    <= crosses && !aliasHit;
      debug_q    <= reqDebug;
      hiStrb_q   <= strb64[7:4];
      hiData_q   <= data64[63:32];
      region_q   <= regionHit;
      pwin_q     <= pwinHit;
      flash_q    <= inRange(reqAddr, FLASH_BASE, FLASH_LAST);
      sramCode_q <= inRange(reqAddr, SRAM_CODE_BASE, SRAM_CODE_LAST);
      sramSys_q  <= inRange(reqAddr, SRAM_SYS_BASE, SRAM_SYS_LAST) ||
                    (aliasHit && inRange(bbTarget, SRAM_SYS_BASE, SRAM_SYS_LAST));
    end
  end

  assign reqReady    = state_q == ST_IDLE;
  assign rspValid    = state_q == ST_RESP;
  assign rspRdata    = rspRdata_q;
  assign rspError    = rspErr_q;
  assign regionSel   = region_q;
  assign periphSel   = pwin_q;
  assign flashSel    = flash_q;
  assign sramCodeSel = sramCode_q;
  assign sramSysSel  = sramSys_q;
  assign busAddr     = busAddr_q;
  assign busWrite    = busWrite_q;
  assign busStrb     = busStrb_q;
  assign busWdata    = busWdata_q;
  assign busDebug    = debug_q;
  // Lock covers the read and write of an alias access so it stays atomic.
  assign busLock     = bb_q && (state_q == ST_LO || state_q == ST_BBW);
endmodule

// [testbench/bus_target_model.sv]
// Memory target standing behind all four router output buses.
// Assumes one bus clock; a slow target waits three extra cycles.
module bus_target_model (
  input  wire logic            core_clk,
  input  wire logic            slow,
  input  wire logic [3:0]      busValid,
  input  wire logic [31:0]     busAddr,
  input  wire logic            busWrite,
  input  wire logic [3:0]      busStrb,
  input  wire logic [31:0]     busWdata,
  output logic      [3:0]      busReady,
  output logic      [3:0][31:0] busRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [int];
  logic [31:0] word;
  logic [1:0]  waitCnt_q = 2'h0;
  initial busReady = '0;
  always @(posedge core_clk) begin
    word = mem.exists(int'(busAddr)) ? mem[int'(busAddr)] : 32'h0000_0000;
    busReady <= '0;
    // Read data is inverted outside the ready cycle so a stale sample shows.
    busRdata <= {4{~word}};
    if (busValid != '0 && busReady == '0) begin
      if (slow && waitCnt_q != 2'h3) waitCnt_q <= waitCnt_q + 2'h1;
      else begin
        waitCnt_q <= 2'h0;
        busReady <= busValid;
        busRdata <= {4{word}};
        for (int i = 0; i < 4; i++)
          if (busWrite && busStrb[i]) word[8*i+:8] = busWdata[8*i+:8];
        mem[int'(busAddr)] = word;
      end
    end
  end
endmodule

// [testbench/address_decode_router_properties.sv]
// Assertions on the router's request, bus and external pins.
// Assumes one bus clock and a synchronous active-low reset.
module address_decode_router_properties (
  input wire logic                                   core_clk,
  input wire logic                                   rst_n,
  input wire logic                                   reqValid,
  input wire logic                                   reqReady,
  input wire logic                                   rspValid,
  input wire logic [addr_map_pkg::NUM_REGIONS-1:0]   regionSel,
  input wire logic [addr_map_pkg::NUM_OUT_BUSES-1:0] busValid,
  input wire logic [addr_map_pkg::NUM_OUT_BUSES-1:0] busReady,
  input wire logic                                   extCsN
);
  timeunit 1ns;
  timeprecision 1ns;
  import addr_map_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence ext_unit; !extCsN [*4]; endsequence
  sequence answered; ##[1:2] (rspValid || busValid != '0); endsequence
  chk_busy_after_take: assert property (reqValid && reqReady |=> !reqReady)
    else $error("ready after take");
  chk_idle_after_rsp: assert property (rspValid |=> reqReady && !rspValid)
    else $error("not idle after response");
  chk_rsp_follows: assert property (|(busValid & busReady) |-> answered)
    else $error("no response after ready");
  chk_code_bus_range: assert property (busValid[0] || busValid[1] |-> regionSel[0])
    else $error("code bus outside code");
  chk_private_bus: assert property (busValid[3] |-> regionSel[REGION_INT_PERIPH])
    else $error("private bus outside region");
  chk_sys_not_code: assert property (busValid[2] |-> !regionSel[REGION_CODE])
    else $error("system bus for code");
  chk_ext_region: assert property (!extCsN |-> regionSel[REGION_EXT_RAM])
    else $error("external select outside window");
  chk_ext_cycle_len: assert property ($fell(extCsN) |-> ext_unit)
    else $error("short external cycle");
endmodule
bind address_decode_router address_decode_router_properties u_props (.*);

// [testbench/address_decode_router_tb.sv]
// Self-checking bench for the address decoder and router.
// Assumes the memory target model answers on all four buses.
module address_decode_router_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import addr_map_pkg::*;
  logic core_clk = 0, rst_n = 0, slow = 0, reqValid = 0, reqWrite = 0, reqFetch = 0;
  logic reqDebug = 0, extWide16 = 0, extSyncMem = 0, reqReady, rspValid, rspError;
  logic busWrite, busLock, busDebug, extDataOe, extCsN, extOeN, extWeN, extAdvN;
  logic extMemClk, flashSel, sramCodeSel, sramSysSel;
  logic [1:0]  reqSize = 0;
  logic [31:0] reqAddr = 0, reqWdata = 0, rspRdata, busAddr, busWdata;
  logic [3:0]  busStrb, busValid, busReady;
  logic [3:0][31:0] busRdata;
  logic [5:0]  regionSel;
  logic [18:0] periphSel;
  logic [23:0] extAddr;
  logic [15:0] extDataOut;
  int          err_total = 0, check_count = 0;
  wire  [15:0] extDataIn = extOeN ? 16'h5A3C : 16'hA5C3;
  always #5 core_clk = ~core_clk;
  address_decode_router u_address_decode_router (.*);
  bus_target_model u_bus_target_model (.*);
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic acc(input logic [31:0] a, wd, e, input logic w, f, input logic [1:0] sz,
                     input int rg, input logic er = 0);
    int n = 0;
    @(posedge core_clk);
    {reqAddr, reqWdata, reqWrite, reqFetch, reqSize, reqValid} <= {a, wd, w, f, sz, 1'b1};
    // Outputs are looked at 1 ns after the edge, once the registers have settled.
    #1;
    while (reqReady !== 1'b1) begin @(posedge core_clk); #1; end
    @(posedge core_clk);
    reqValid <= 1'b0;
    #1;
    while (rspValid !== 1'b1 && n < 300) begin @(posedge core_clk); #1; n++; end
    chk("rspValid", 1, rspValid);
    chk("rspRdata", e, rspRdata);
    chk("rspError", er, rspError);
    chk("regionSel", 32'(1 << rg), 32'(regionSel));
  endtask
  task automatic sram_rw;
    acc(32'h2000_0010, 32'h1234_5678, 0, 1, 0, 2, REGION_SRAM);
    acc(32'h2000_0010, 0, 32'h1234_5678, 0, 1, 2, REGION_SRAM);
  endtask
  task automatic bit_band;
    acc(32'h2200_000C, 1, 0, 1, 0, 2, REGION_SRAM);
    acc(32'h2200_000C, 0, 1, 0, 0, 2, REGION_SRAM);
    acc(32'h2000_0000, 0, 32'h0000_0008, 0, 0, 2, REGION_SRAM);
  endtask
  task automatic unaligned;
    slow <= 1;
    acc(32'h2000_0013, 0, 32'h0000_0012, 0, 0, 1, REGION_SRAM);
    slow <= 0;
  endtask
  task automatic fetch_refused;
    acc(32'h4000_5400, 0, 0, 0, 0, 2, REGION_PERIPH);
    chk("periphSel", 1, periphSel[PWIN_EXT_CTRL]);
    acc(32'h4000_5400, 0, 0, 0, 1, 2, REGION_PERIPH, 1);
    acc(32'h6000_0000, 0, 0, 0, 1, 2, REGION_EXT_RAM, 1);
  endtask
  task automatic ext_read;
    acc(32'h6000_0000, 0, 32'hC3C3_C3C3, 0, 0, 2, REGION_EXT_RAM);
    {extWide16, extSyncMem} <= 2'h3;
    acc(32'h6000_0004, 0, 32'hA5C3_A5C3, 0, 1, 2, REGION_EXT_RAM);
  endtask
  task automatic code_private;
    acc(32'h1FFF_8000, 32'hCAFE_0001, 0, 1, 0, 2, REGION_CODE);
    acc(32'h1FFF_8000, 0, 32'hCAFE_0001, 0, 1, 2, REGION_CODE);
    chk("sramCodeSel", 1, sramCodeSel);
    reqDebug <= 1;
    acc(32'hE000_0100, 0, 0, 0, 0, 2, REGION_INT_PERIPH);
    chk("busDebug", 1, busDebug);
    reqDebug <= 0;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1;
    sram_rw;
    bit_band;
    unaligned;
    fetch_refused;
    ext_read;
    code_private;
    results;
  end
  initial begin
    #100us;
    err_total++;
    results;
  end
endmodule
